// >>> design/pod_req_qual.sv
// Purpose: one request input: synchroniser, edge and low-level qualifier
// Assumes: sampling strobes are single-cycle pulses on clk
// Notes: hit is a one-cycle pulse from a flip-flop
`timescale 1ns/10ps
module pod_req_qual (
  input logic clk,
  input logic rst_n,
  input logic req_in_n,
  input logic [1:0] mode,
  input logic strobe8,
  input logic strobe16,
  input logic strobe128,
  output logic hit
);
  import pod_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [SAMPLE_CNT_W-1:0] cnt;
    logic hit;
  } pod_qual_t;

  pod_qual_t st_ff;
  pod_qual_t nxt_st;
  pod_mode_t sel;

  always_comb begin
    logic strobe;
    strobe = 1'b0;
    nxt_st = st_ff;
    sel = pod_mode_t'(mode);
    nxt_st.sync1 = req_in_n;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    nxt_st.hit = 1'b0;
    unique case (sel)
      POD_MODE_EDGE: begin
        strobe = 1'b0;
      end
      POD_MODE_DIV8: begin
        strobe = strobe8;
      end
      POD_MODE_DIV16: begin
        strobe = strobe16;
      end
      POD_MODE_DIV128: begin
        strobe = strobe128;
      end
    endcase
    if (sel == POD_MODE_EDGE) begin
      nxt_st.cnt = '0;
      nxt_st.hit = st_ff.prev & ~st_ff.sync2;
    end else if (strobe) begin
      if (st_ff.sync2) begin
        // any high sample breaks the run and restarts it
        nxt_st.cnt = '0;
      end else if (st_ff.cnt == LOW_LAST) begin
        nxt_st.cnt = '0;
        nxt_st.hit = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + SAMPLE_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle-high pin level so reset release is not seen as an edge
      st_ff <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, cnt: '0, hit: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hit = st_ff.hit;

endmodule

// >>> design/pod_top.sv
// Purpose: port output disable unit, forces high-current pins to high-z
// Assumes: rst_n is the external power-on reset; other resets do not reach
// Notes: registers on APB, 16-bit data in the low half-word
//
// Overview of operation
// - two-bit mode fields for inputs 2,1,0 at bits 5:4, 3:2, 1:0.
// - mode 00 accepts a request on a high-to-low edge.
// - modes 01/10/11 need sixteen low samples at clk/8, /16, /128.
// - any high sample inside the window rejects the low-level request.
// - an accepted request puts every high-current pin in high impedance.
// - short register: flag bit 15, compare enable 9, interrupt enable 8.
// - short flag sets when any compared pair is low on both pins.
// - short flag clears by writing 0 after reading 1; writing 1 ignored.
// - short triggers high impedance only if interrupt enable is also set.
// - compare and interrupt enable together raise interrupt with high-z.
// - enabling compare while a pair is low sets the flag immediately.
// - short high impedance sets port E data bits 15..11 and 9.
// - compare and interrupt enables reset to 0, disabling their function.
// - short register reserved bits 14..10 and 7..0 read 0.
// - short register clears only on power-on reset.
// - input high impedance releases on reset or all four flags cleared.
// - short high impedance releases after compare off then flag cleared.
// - input flags 15..12 set on requests, clear by 0 after reading 1.
// - input interrupt enable bit 8 requests interrupt when any flag set.
// - input 3 mode field sits at bits 7:6 with same encoding.
// - a pair counts as short only when low longer than one cycle; the write that turns compare on flags a pair low on a single sample.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module pod_top (
  input logic clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [pod_pkg::PADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input logic [pod_pkg::NUM_REQ-1:0] output_disable_request_in_n,
  input logic timer_io_3b,
  input logic timer_io_3d,
  input logic timer_io_4a,
  input logic timer_io_4c,
  input logic timer_io_4b,
  input logic timer_io_4d,
  output logic high_current_hiz,
  output logic input_irq,
  output logic short_irq,
  output logic [15:0] port_e_output_data_set
);
  import pod_pkg::*;

  typedef struct packed {
    logic [NUM_REQ-1:0] in_flag;
    logic [NUM_REQ-1:0] in_armed;
    logic in_irq_en;
    logic [2*NUM_REQ-1:0] mode;
    logic short_flag;
    logic short_armed;
    logic cmp_en;
    logic short_irq_en;
    logic [2*NUM_PAIR-1:0] pin_sync1;
    logic [2*NUM_PAIR-1:0] pin_sync2;
    logic [NUM_PAIR-1:0] pair_low_prev;
    logic short_hiz;
    logic [PRESC_W-1:0] presc;
    logic strobe8;
    logic strobe16;
    logic strobe128;
    logic hiz;
    logic irq_in;
    logic irq_short;
    logic [15:0] pe_set;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } pod_state_t;

  pod_state_t st_ff;
  pod_state_t nxt_st;
  logic [NUM_REQ-1:0] req_hit;

  // address decode, shared by the read mux and the write path
  function automatic logic [1:0] pod_decode(
    input logic [PADDR_W-1:0] addr
  );
    logic [1:0] sel;
    sel = 2'b00;
    if (addr == INPUT_DETECT_OFS) begin
      sel = 2'b01;
    end else if (addr == OUTPUT_SHORT_OFS) begin
      sel = 2'b10;
    end
    return sel;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
      pod_req_qual pod_req_qual_inst (
        .clk(clk),
        .rst_n(rst_n),
        .req_in_n(output_disable_request_in_n[gi]),
        .mode(st_ff.mode[IN_MODE_LSB+IN_MODE_W*gi +: IN_MODE_W]),
        .strobe8(st_ff.strobe8),
        .strobe16(st_ff.strobe16),
        .strobe128(st_ff.strobe128),
        .hit(req_hit[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [1:0] sel;
    logic setup;
    logic access;
    logic wr_in;
    logic wr_sh;
    logic [15:0] rd_in;
    logic [15:0] rd_sh;
    logic [15:0] wd;
    logic [NUM_PAIR-1:0] low_now;
    logic [NUM_PAIR-1:0] low_long;
    logic [NUM_REQ-1:0] in_clr;
    logic short_clr;
    logic short_set;
    logic cmp_en_rise;
    sel = pod_decode(paddr);
    setup = psel & ~penable;
    access = psel & penable & st_ff.pready;
    wr_in = access & pwrite & sel[0];
    wr_sh = access & pwrite & sel[1];
    wd = pwdata[15:0];
    nxt_st = st_ff;

    // register images; reserved bits read as zero
    rd_in = '0;
    rd_in[IN_FLAG_LSB +: NUM_REQ] = st_ff.in_flag;
    rd_in[IN_IRQ_EN_BIT] = st_ff.in_irq_en;
    rd_in[IN_MODE_LSB +: 2*NUM_REQ] = st_ff.mode;
    rd_sh = '0;
    rd_sh[SHORT_FLAG_BIT] = st_ff.short_flag;
    rd_sh[CMP_EN_BIT] = st_ff.cmp_en;
    rd_sh[SHORT_IRQ_EN_BIT] = st_ff.short_irq_en;

    // free-running prescaler, strobes one cycle wide
    nxt_st.presc = st_ff.presc + PRESC_W'(1);
    nxt_st.strobe8 = (st_ff.presc & DIV8_MASK) == DIV8_MASK;
    nxt_st.strobe16 = (st_ff.presc & DIV16_MASK) == DIV16_MASK;
    nxt_st.strobe128 = st_ff.presc == DIV128_MASK;

    // timer pin levels come from pads, so sync before comparing
    nxt_st.pin_sync1 = {timer_io_4d, timer_io_4b, timer_io_4c,
                        timer_io_4a, timer_io_3d, timer_io_3b};
    nxt_st.pin_sync2 = st_ff.pin_sync1;
    for (int p = 0; p < NUM_PAIR; p++) begin
      low_now[p] = ~st_ff.pin_sync2[2*p] & ~st_ff.pin_sync2[2*p+1];
    end
    nxt_st.pair_low_prev = low_now;
    // low on two consecutive samples: longer than one cycle
    low_long = low_now & st_ff.pair_low_prev;

    // apb: answer in the first access cycle, data captured at setup
    nxt_st.pready = setup;
    nxt_st.pslverr = setup & (sel == 2'b00);
    nxt_st.prdata = '0;
    if (setup & ~pwrite) begin
      nxt_st.prdata = {16'h0000, sel[0] ? rd_in : (sel[1] ? rd_sh : 16'h0000)};
    end

    // flag arming: a flag is clearable only after it was read as one
    if (access & ~pwrite & sel[0]) begin
      nxt_st.in_armed = st_ff.prdata[IN_FLAG_LSB +: NUM_REQ];
    end
    if (access & ~pwrite & sel[1]) begin
      nxt_st.short_armed = st_ff.prdata[SHORT_FLAG_BIT];
    end

    // input detect register writes
    in_clr = '0;
    if (wr_in & pstrb[1]) begin
      in_clr = st_ff.in_armed & ~wd[IN_FLAG_LSB +: NUM_REQ];
      nxt_st.in_irq_en = wd[IN_IRQ_EN_BIT];
      nxt_st.in_armed = '0;
    end
    if (wr_in & pstrb[0]) begin
      nxt_st.mode = wd[IN_MODE_LSB +: 2*NUM_REQ];
    end
    // a request in the clearing cycle keeps its flag
    nxt_st.in_flag = req_hit | (st_ff.in_flag & ~in_clr);

    // output short register writes
    short_clr = 1'b0;
    cmp_en_rise = 1'b0;
    if (wr_sh & pstrb[1]) begin
      short_clr = st_ff.short_armed & ~wd[SHORT_FLAG_BIT];
      nxt_st.cmp_en = wd[CMP_EN_BIT];
      nxt_st.short_irq_en = wd[SHORT_IRQ_EN_BIT];
      nxt_st.short_armed = 1'b0;
      cmp_en_rise = ~st_ff.cmp_en & wd[CMP_EN_BIT];
    end
    // a pair already low when compare turns on flags in the same write
    short_set = (st_ff.cmp_en & |low_long)
              | (cmp_en_rise & |low_now);
    nxt_st.short_flag = short_set
                      | (st_ff.short_flag & ~short_clr);

    // short high-z latches; held until compare off and flag cleared
    if (st_ff.short_flag & st_ff.cmp_en & st_ff.short_irq_en) begin
      nxt_st.short_hiz = 1'b1;
    end else if (~st_ff.short_flag & ~st_ff.cmp_en) begin
      nxt_st.short_hiz = 1'b0;
    end
    // port e bits forced high on entry into short high-z
    nxt_st.pe_set = (nxt_st.short_hiz & ~st_ff.short_hiz) ?
                    PORT_E_FORCE_MASK : 16'h0000;

    // input flags hold high-z until all four are cleared
    nxt_st.hiz = (|st_ff.in_flag) | st_ff.short_hiz;
    nxt_st.irq_in = st_ff.in_irq_en & (|st_ff.in_flag);
    // raised alongside the short high-z request
    nxt_st.irq_short = st_ff.short_flag & st_ff.cmp_en
                     & st_ff.short_irq_en;
  end

  // only the power-on reset clears the registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.in_irq_en <= INPUT_DETECT_RESET[IN_IRQ_EN_BIT];
      st_ff.cmp_en <= OUTPUT_SHORT_RESET[CMP_EN_BIT];
      st_ff.short_irq_en <= OUTPUT_SHORT_RESET[SHORT_IRQ_EN_BIT];
      st_ff.pin_sync1 <= '1;
      st_ff.pin_sync2 <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready = st_ff.pready;
  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.pslverr;
  assign high_current_hiz = st_ff.hiz;
  assign input_irq = st_ff.irq_in;
  assign short_irq = st_ff.irq_short;
  assign port_e_output_data_set = st_ff.pe_set;

endmodule

// >>> include/pod_pkg.sv
// Purpose: shared constants and types of the port output disable unit
// Assumes: 32-bit APB register bus, 16-bit registers in the low half-word
// Notes: register offsets are byte addresses on the APB window
package pod_pkg;

  localparam int PADDR_W = 8;
  localparam int NUM_REQ = 4;
  localparam int NUM_PAIR = 3;
  localparam int PRESC_W = 7;
  localparam int SAMPLE_CNT_W = 4;

  // register byte offsets
  localparam logic [PADDR_W-1:0] INPUT_DETECT_OFS = 8'h00;
  localparam logic [PADDR_W-1:0] OUTPUT_SHORT_OFS = 8'h04;

  // input_detect_ctrl_status fields
  localparam int IN_FLAG_LSB = 12;
  localparam int IN_IRQ_EN_BIT = 8;
  localparam int IN_MODE_LSB = 0;
  localparam int IN_MODE_W = 2;
  localparam logic [15:0] INPUT_DETECT_RESET = 16'h0000;

  // output_short_ctrl_status fields
  localparam int SHORT_FLAG_BIT = 15;
  localparam int CMP_EN_BIT = 9;
  localparam int SHORT_IRQ_EN_BIT = 8;
  localparam logic [15:0] OUTPUT_SHORT_RESET = 16'h0000;

  // port e data bits forced high on a short: 15..11 and 9
  localparam logic [15:0] PORT_E_FORCE_MASK = 16'hfa00;

  // low-level qualification: sixteen samples, counter reaches fifteen
  localparam int LOW_SAMPLES = 16;
  localparam logic [SAMPLE_CNT_W-1:0] LOW_LAST =
    SAMPLE_CNT_W'(LOW_SAMPLES - 1);

  // prescaler terminal counts for the three sampling rates
  localparam logic [PRESC_W-1:0] DIV8_MASK = 7'h07;
  localparam logic [PRESC_W-1:0] DIV16_MASK = 7'h0f;
  localparam logic [PRESC_W-1:0] DIV128_MASK = 7'h7f;

  // pair must be low longer than one clock cycle
  localparam int SHORT_MIN_CYCLES = 1;

  typedef enum logic [1:0] {
    POD_MODE_EDGE   = 2'b00,
    POD_MODE_DIV8   = 2'b01,
    POD_MODE_DIV16  = 2'b10,
    POD_MODE_DIV128 = 2'b11
  } pod_mode_t;

endpackage

// >>> test/pod_asserts.sv
// Purpose: port checks of the output disable unit
// Assumes: enables are shadowed from apb writes with the high strobe set
// Notes: bound to pod_top
`timescale 1ns/10ps
module pod_asserts (
  input logic clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [pod_pkg::PADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic pready,
  input logic [31:0] prdata,
  input logic timer_io_3b,
  input logic timer_io_3d,
  input logic high_current_hiz,
  input logic input_irq,
  input logic short_irq,
  input logic [15:0] port_e_output_data_set
);
  import pod_pkg::*;
  logic [2:0] en_ff;
  logic wr_hi;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign wr_hi = psel && penable && pready && pwrite && pstrb[1];
  // input enable, compare enable, short enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= 3'h0;
    end else if (wr_hi && paddr == INPUT_DETECT_OFS) begin
      en_ff[2] <= pwdata[IN_IRQ_EN_BIT];
    end else if (wr_hi && paddr == OUTPUT_SHORT_OFS) begin
      en_ff[1:0] <= pwdata[CMP_EN_BIT:SHORT_IRQ_EN_BIT];
    end
  end
  property p_short_set;
    (en_ff[1:0] == 2'h3 && !timer_io_3b && !timer_io_3d) [*8] |-> short_irq;
  endproperty
  a_short_set: assert property (p_short_set)
    else $error("short not flagged");
  property p_irq_en_off; !en_ff[0] |=> !short_irq; endproperty
  a_irq_en_off: assert property (p_irq_en_off)
    else $error("short irq while disabled");
  property p_cmp_off; !en_ff[1] |=> !short_irq; endproperty
  a_cmp_off: assert property (p_cmp_off)
    else $error("short irq without compare");
  property p_in_en_off; !en_ff[2] |=> !input_irq; endproperty
  a_in_en_off: assert property (p_in_en_off)
    else $error("input irq while disabled");
  property p_pe_val;
    port_e_output_data_set != 16'h0000 |->
      port_e_output_data_set == PORT_E_FORCE_MASK && short_irq;
  endproperty
  a_pe_val: assert property (p_pe_val)
    else $error("bad port data set");
  property p_pe_pulse;
    port_e_output_data_set != 16'h0000 |=> port_e_output_data_set == 16'h0000;
  endproperty
  a_pe_pulse: assert property (p_pe_pulse)
    else $error("port data set too long");
  property p_rsv;
    pready && !pwrite && paddr == OUTPUT_SHORT_OFS |->
      prdata[14:10] == 5'h00 && prdata[7:0] == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits set");
  property p_in_hiz; input_irq |-> high_current_hiz; endproperty
  a_in_hiz: assert property (p_in_hiz)
    else $error("input irq without high-z");
  property p_sh_hiz; $rose(short_irq) |=> high_current_hiz; endproperty
  a_sh_hiz: assert property (p_sh_hiz)
    else $error("short irq without high-z");
endmodule
bind pod_top pod_asserts pod_asserts_inst (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .timer_io_3b(timer_io_3b), .timer_io_3d(timer_io_3d),
  .high_current_hiz(high_current_hiz), .input_irq(input_irq),
  .short_irq(short_irq), .port_e_output_data_set(port_e_output_data_set));

// >>> test/pod_pins_model.sv
// Purpose: far side model of request lines and timer output pairs
// Assumes: commands change just after a rising clock edge
// Notes: every pin idles high
`timescale 1ns/10ps
module pod_pins_model (
  input logic [3:0] req_low,
  input logic [2:0] pair_low,
  output logic [3:0] req_n,
  output logic [5:0] tio
);
  // lines held high unless a request is commanded
  assign req_n = ~req_low;
  // pair pins fall together, else drive high before any flag clear
  assign tio = ~{{2{pair_low[2]}}, {2{pair_low[1]}},
                 {2{pair_low[0]}}};
endmodule

// >>> test/tb_pod_top.sv
// Purpose: self-checking bench of the output disable unit
// Assumes: zero-wait apb slave, full strobes
// Notes: pins are driven through the pin model
`timescale 1ns/10ps
module tb_pod_top;
  import pod_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, hiz, iirq, sirq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] pe;
  logic [15:0] pe_seen = 16'h0000;
  logic [3:0] req_low, req_n;
  logic [2:0] pair_low;
  logic [5:0] tio;
  logic e;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  pod_top pod_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .output_disable_request_in_n(req_n), .timer_io_3b(tio[0]),
    .timer_io_3d(tio[1]), .timer_io_4a(tio[2]), .timer_io_4c(tio[3]),
    .timer_io_4b(tio[4]), .timer_io_4d(tio[5]), .high_current_hiz(hiz),
    .input_irq(iirq), .short_irq(sirq), .port_e_output_data_set(pe));
  pod_pins_model pod_pins_model_inst (.req_low(req_low),
    .pair_low(pair_low), .req_n(req_n), .tio(tio));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (pe !== 16'h0000) pe_seen <= pe;
    if (cycles == 40000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    // no local wait limit: only the bench timeout ends a stuck transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(r, {16'h0000, exp});
  endtask
  task automatic t_regs();
    rd(OUTPUT_SHORT_OFS, 16'h0000);
    rd(INPUT_DETECT_OFS, 16'h0000);
    apb(1'b0, 8'h08, 16'h0000);
    chk(32'(e), 32'h1);
    apb(1'b1, OUTPUT_SHORT_OFS, 16'hffff);
    rd(OUTPUT_SHORT_OFS, 16'h0300);
    apb(1'b1, INPUT_DETECT_OFS, 16'hffff);
    rd(INPUT_DETECT_OFS, 16'h01ff);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd(OUTPUT_SHORT_OFS, 16'h0000);
  endtask
  task automatic t_edge();
    for (int i = 0; i < 4; i++) begin
      req_low[i] <= 1'b1;
      cyc(10);
      chk(32'(hiz), 32'h1);
      chk(32'(iirq), 32'h0);
      apb(1'b1, INPUT_DETECT_OFS, 16'h0000);
      rd(INPUT_DETECT_OFS, 16'h1000 << i);
      req_low[i] <= 1'b0;
      apb(1'b1, INPUT_DETECT_OFS, 16'h0000);
      rd(INPUT_DETECT_OFS, 16'h0000);
      chk(32'(hiz), 32'h0);
    end
  endtask
  task automatic t_level();
    int p;
    logic [15:0] c;
    for (int m = 1; m < 4; m++) begin
      p = (m == 3) ? 128 : 8 << (m - 1);
      c = 16'h0100 | (16'(m) << (2 * m));
      apb(1'b1, INPUT_DETECT_OFS, c);
      req_low[m] <= 1'b1;
      cyc(10 * p);
      req_low[m] <= 1'b0;
      cyc(2 * p);
      req_low[m] <= 1'b1;
      cyc(10 * p);
      chk(32'(hiz), 32'h0);
      cyc(9 * p);
      chk(32'(iirq), 32'h1);
      rd(INPUT_DETECT_OFS, c | (16'h1000 << m));
      req_low[m] <= 1'b0;
      apb(1'b1, INPUT_DETECT_OFS, 16'h0000);
      cyc(2);
      chk(32'(hiz), 32'h0);
    end
  endtask
  task automatic t_short();
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OUTPUT_SHORT_OFS, 16'h0300);
      pair_low[k] <= 1'b1;
      @(posedge clk);
      pair_low[k] <= 1'b0;
      cyc(8);
      rd(OUTPUT_SHORT_OFS, 16'h0300);
      pair_low[k] <= 1'b1;
      cyc(8);
      chk(32'(sirq), 32'h1);
      chk(32'(hiz), 32'h1);
      rd(OUTPUT_SHORT_OFS, 16'h8300);
      pair_low[k] <= 1'b0;
      apb(1'b1, OUTPUT_SHORT_OFS, 16'h8000);
      rd(OUTPUT_SHORT_OFS, 16'h8000);
      chk(32'(hiz), 32'h1);
      apb(1'b1, OUTPUT_SHORT_OFS, 16'h0000);
      rd(OUTPUT_SHORT_OFS, 16'h0000);
      chk(32'(hiz), 32'h0);
    end
    chk(32'(pe_seen), 32'(PORT_E_FORCE_MASK));
  endtask
  task automatic t_late();
    pair_low[0] <= 1'b1;
    cyc(8);
    rd(OUTPUT_SHORT_OFS, 16'h0000);
    apb(1'b1, OUTPUT_SHORT_OFS, 16'h0200);
    rd(OUTPUT_SHORT_OFS, 16'h8200);
    chk(32'(hiz), 32'h0);
    pair_low[0] <= 1'b0;
    apb(1'b1, OUTPUT_SHORT_OFS, 16'h0000);
    rd(OUTPUT_SHORT_OFS, 16'h0000);
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    req_low = 4'h0;
    pair_low = 3'h0;
    cyc(20);
    rst_n <= 1'b1;
    t_regs();
    t_edge();
    t_level();
    t_short();
    t_late();
    summarize();
  end
endmodule
